/* File: imu_regs_consts.vh */
// Purpose: Shared constants for the burst, checksum and bias register block
// Assumes: Byte addresses as seen on the serial link, 16-bit registers
// Notes:   Definitions only
`ifndef IMU_REGS_CONSTS_VH
`define IMU_REGS_CONSTS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_GYRO_X_BIAS_LOW  7'h40
`define ADDR_GYRO_X_BIAS_HIGH 7'h42
`define ADDR_GYRO_Y_BIAS_LOW  7'h44
`define ADDR_GYRO_Y_BIAS_HIGH 7'h46
`define ADDR_GYRO_Z_BIAS_LOW  7'h48
`define ADDR_GYRO_Z_BIAS_HIGH 7'h4A
`define ADDR_XFER_CHECKSUM    7'h3E
`define ADDR_QUEUED_COUNT     7'h3C
`define ADDR_BURST            7'h7C
`define ADDR_MISC_CONTROL     7'h64
`define ADDR_BIAS_EST_CONFIG  7'h66
`define ADDR_GLOBAL_COMMAND   7'h68
`define ADDR_DIAG_FLAGS       7'h02

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define BIAS_RESET            16'h0000
`define CHECKSUM_RESET        16'h0000
`define MISC_RESET            16'h0000
`define EST_CONFIG_RESET      16'h0000
`define MISC_SCALED_SYNC_BIT  1
`define MISC_WIDE_TIME_BIT    3
`define MISC_WIDE_BURST_BIT   9
`define MISC_OUT_SELECT_BIT   8
`define EST_AXIS_EN_HI        13
`define EST_AXIS_EN_LO        8
`define EST_TIME_BASE_HI      3
`define EST_TIME_BASE_LO      0
`define CMD_BIAS_UPDATE_BIT   0

// ----------------------------------------
// Burst layout
// ----------------------------------------
`define BURST_LAST_NARROW     5'd10
`define BURST_LAST_WIDE       5'd17

`endif

/* File: byte_checksum.v */
// Purpose: Byte-wise 16-bit running sum of transmitted words
// Assumes: Clear has priority over add in the same cycle
// Notes:   Carry out of bit 15 is dropped
`include "imu_regs_consts.vh"
module byte_checksum (
  input  wire        i_clk,
  input  wire        i_rst_b,
  input  wire        i_clear,
  input  wire        i_add,
  input  wire [15:0] i_word,
  output reg  [15:0] o_sum
);
  wire [15:0] sum_d;

  // Upper byte then lower byte, wrap modulo 65536
  assign sum_d = o_sum + {8'h00, i_word[15:8]} + {8'h00, i_word[7:0]}; // [RULE1] [RULE2]

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sum <= `CHECKSUM_RESET;
    end else if (i_clear) begin
      o_sum <= `CHECKSUM_RESET;
    end else if (i_add) begin
      o_sum <= sum_d;
    end
  end
endmodule // byte_checksum

/* File: spi_shift.v */
// Purpose: 16-bit serial slave shifter, mode 3, sampled on the system clock
// Assumes: Pins already pass two flip-flops in the caller
// Notes:   One word per frame edge count of 16
module spi_shift (
  input  wire        i_clk,
  input  wire        i_rst_b,
  input  wire        i_sel,
  input  wire        i_sclk,
  input  wire        i_mosi,
  input  wire [15:0] i_tx,
  output reg         o_miso,
  output reg         o_word_done,
  output reg  [15:0] o_rx
);
  reg        sclk_q;
  reg [3:0]  cnt_q;
  reg [15:0] tx_q;
  wire       rise;
  wire       fall;

  assign rise = i_sel & i_sclk & ~sclk_q;
  assign fall = i_sel & ~i_sclk & sclk_q;

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_q      <= 1'b1;
      cnt_q       <= 4'h0;
      tx_q        <= 16'h0000;
      o_miso      <= 1'b0;
      o_word_done <= 1'b0;
      o_rx        <= 16'h0000;
    end else begin
      sclk_q      <= i_sclk;
      o_word_done <= 1'b0;
      if (!i_sel) begin
        cnt_q  <= 4'h0;
        tx_q   <= i_tx;
        o_miso <= i_tx[15];
      end else if (fall) begin
        // First falling edge presents bit 15 already on the pin
        if (cnt_q != 4'h0) begin
          o_miso <= tx_q[15];
        end
      end else if (rise) begin
        o_rx  <= {o_rx[14:0], i_mosi};
        tx_q  <= {tx_q[14:0], 1'b0};
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == 4'hF) begin
          o_word_done <= 1'b1;
        end
      end
    end
  end
endmodule // spi_shift

/* File: imu_burst_checksum_bias_regs.v */
// Purpose: Burst read sequencer, transfer checksum and gyro bias registers
// Assumes: Each 16-bit frame carries a command; reads answer in the next frame
// Notes:   Sample data and estimates come from the datapath on i_clk
//
// Behaviour
// RULE1 - Checksum adds upper byte then lower byte
// RULE2 - Checksum keeps sixteen bits, wraps modulo 65536
// RULE3 - New sample clears checksum, reads accumulate
// RULE4 - Host finishes validated reads within one sample
// RULE5 - Host treats mismatch as corrupt or incoherent
// RULE6 - Burst checksum equals readable checksum register
// RULE7 - Words 0 and 1 excluded from checksum
// RULE8 - Narrow burst: upper words, temperature, counter, checksum
// RULE9 - Wide burst: low/high pairs, time words, checksum
// RULE10 - Output select picks rate or step samples
// RULE11 - Scaled sync swaps counter for low timestamp
// RULE12 - Wide time bit picks zeros or high timestamp
// RULE13 - Host issues one extra word for checksum
// RULE14 - Each gyro axis has 32-bit bias pair
// RULE15 - User bias added after factory correction
// RULE16 - Estimator config: axis enables, time base
// RULE17 - Global command bit 0 loads estimates
// RULE18 - Bias writes act on output immediately
// RULE19 - Bias registers read/write, reset zero, saved
// RULE20 - Bias words at 0x40 through 0x4A
`include "imu_regs_consts.vh"
module imu_burst_checksum_bias_regs (
  input  wire         i_clk,
  input  wire         i_rst_b,
  input  wire         i_cs_b,
  input  wire         i_sclk,
  input  wire         i_mosi,
  input  wire         i_sample_load,
  input  wire [191:0] i_rate,
  input  wire [191:0] i_step,
  input  wire [15:0]  i_temperature,
  input  wire [15:0]  i_sample_counter,
  input  wire [31:0]  i_sync_time,
  input  wire [15:0]  i_queued_sample_count,
  input  wire [15:0]  i_diagnostic_flags,
  input  wire [95:0]  i_bias_estimate,
  input  wire [95:0]  i_factory_gyro,
  output reg          o_miso,
  output reg  [95:0]  o_gyro_corrected,
  output reg  [5:0]   o_axis_estimate_en,
  output reg  [3:0]   o_estimate_time_base,
  output reg  [95:0]  o_flash_backup
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [1:0] cs_s;
  reg [1:0] sclk_s;
  reg [1:0] mosi_s;

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cs_s   <= 2'b11;
      sclk_s <= 2'b11;
      mosi_s <= 2'b00;
    end else begin
      cs_s   <= {cs_s[0], i_cs_b};
      sclk_s <= {sclk_s[0], i_sclk};
      mosi_s <= {mosi_s[0], i_mosi};
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [15:0] bias_q [0:5];
  reg  [15:0] misc_q;
  reg  [15:0] est_cfg_q;
  reg  [15:0] tx_word;
  reg  [6:0]  rd_addr_q;
  reg         burst_q;
  reg  [4:0]  bidx_q;
  reg         rd_pend_q;
  wire        word_done;
  wire        shift_miso;
  wire [15:0] rx;
  wire [15:0] checksum;
  wire        wr;
  wire [6:0]  addr;
  wire        wide;
  wire [15:0] ts_high;
  wire [15:0] ts_low_or_cnt;
  wire [191:0] inertial;
  wire [4:0]  last_idx;
  wire        counted;
  integer     k;
  integer     m;
  // Byte pairing state, read by the command decode below
  reg  [7:0]  low_byte_q;
  reg  [6:0]  low_addr_q;
  reg         low_valid_q;
  wire        wr_full;
  wire [6:0]  full_addr;
  wire [15:0] full_data;

  assign wr   = rx[15];
  assign addr = rx[14:8];
  assign wide = misc_q[`MISC_WIDE_BURST_BIT];
  // Rate versus step samples
  assign inertial = misc_q[`MISC_OUT_SELECT_BIT] ? i_step : i_rate;               // [RULE10]
  assign ts_low_or_cnt = misc_q[`MISC_SCALED_SYNC_BIT] ? i_sync_time[15:0]
                                                       : i_sample_counter;        // [RULE11]
  assign ts_high = misc_q[`MISC_WIDE_TIME_BIT] ? i_sync_time[31:16] : 16'h0000;  // [RULE12]
  assign last_idx = wide ? `BURST_LAST_WIDE : `BURST_LAST_NARROW;

  // ----------------------------------------
  // Word selection
  // ----------------------------------------
  // Channel c of inertial: bits [32c+31:32c], high word on top
  always @* begin
    tx_word = 16'h0000;
    if (burst_q) begin
      if (bidx_q == 5'd0) begin
        tx_word = i_queued_sample_count;
      end else if (bidx_q == 5'd1) begin
        tx_word = i_diagnostic_flags;
      end else if (bidx_q == last_idx) begin
        tx_word = checksum;                                                       // [RULE6]
      end else if (!wide) begin
        case (bidx_q)
          5'd2, 5'd3, 5'd4, 5'd5, 5'd6, 5'd7: begin
            tx_word = inertial[(bidx_q - 5'd2) * 32 + 16 +: 16];                  // [RULE8]
          end
          5'd8: begin
            tx_word = i_temperature;                                              // [RULE8]
          end
          5'd9: begin
            tx_word = ts_low_or_cnt;                                              // [RULE8]
          end
          default: begin
            tx_word = 16'h0000;
          end
        endcase
      end else begin
        case (bidx_q)
          5'd14: begin
            tx_word = i_temperature;                                              // [RULE9]
          end
          5'd15: begin
            tx_word = ts_low_or_cnt;                                              // [RULE9]
          end
          5'd16: begin
            tx_word = ts_high;                                                    // [RULE9]
          end
          default: begin
            // Lower word on even index, upper on odd
            tx_word = inertial[(bidx_q - 5'd2) * 16 +: 16];                       // [RULE9]
          end
        endcase
      end
    end else if (rd_pend_q) begin
      case (rd_addr_q)
        `ADDR_GYRO_X_BIAS_LOW:  tx_word = bias_q[0];                              // [RULE19]
        `ADDR_GYRO_X_BIAS_HIGH: tx_word = bias_q[1];
        `ADDR_GYRO_Y_BIAS_LOW:  tx_word = bias_q[2];
        `ADDR_GYRO_Y_BIAS_HIGH: tx_word = bias_q[3];
        `ADDR_GYRO_Z_BIAS_LOW:  tx_word = bias_q[4];
        `ADDR_GYRO_Z_BIAS_HIGH: tx_word = bias_q[5];
        `ADDR_XFER_CHECKSUM:    tx_word = checksum;
        `ADDR_QUEUED_COUNT:     tx_word = i_queued_sample_count;
        `ADDR_DIAG_FLAGS:       tx_word = i_diagnostic_flags;
        `ADDR_MISC_CONTROL:     tx_word = misc_q;
        `ADDR_BIAS_EST_CONFIG:  tx_word = est_cfg_q;
        default:                tx_word = 16'h0000;
      endcase
    end
  end

  // Words 0 and 1 and the checksum word itself are not summed
  assign counted = word_done & (burst_q ? (bidx_q > 5'd1) && (bidx_q != last_idx)
                                        : rd_pend_q && (rd_addr_q != `ADDR_XFER_CHECKSUM)); // [RULE7]

  spi_shift u_shift (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_sel       (~cs_s[1]),
    .i_sclk      (sclk_s[1]),
    .i_mosi      (mosi_s[1]),
    .i_tx        (tx_word),
    .o_miso      (shift_miso),
    .o_word_done (word_done),
    .o_rx        (rx)
  );

  // Fresh sample clears, every transmitted word except burst words 0 and 1 and the checksum accumulates
  byte_checksum u_sum (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_clear (i_sample_load),                                     // [RULE3] [RULE5]
    .i_add   (counted),                                                           // [RULE3]
    .i_word  (tx_word),
    .o_sum   (checksum)
  );

  // ----------------------------------------
  // Command decode and sequencing
  // ----------------------------------------
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (k = 0; k < 6; k = k + 1) begin
        bias_q[k] <= `BIAS_RESET;
      end
      misc_q    <= `MISC_RESET;
      est_cfg_q <= `EST_CONFIG_RESET;
      rd_addr_q <= 7'h00;
      rd_pend_q <= 1'b0;
      burst_q   <= 1'b0;
      bidx_q    <= 5'd0;
    end else begin
      if (word_done) begin
        if (burst_q) begin
          // Sequence ends once the checksum word has gone out
          if (bidx_q == last_idx) begin
            burst_q <= 1'b0;                                                      // [RULE13]
            bidx_q  <= 5'd0;
          end else begin
            bidx_q <= bidx_q + 5'd1;
          end
          rd_pend_q <= 1'b0;
        end else if (wr) begin
          // No register moves on a lone byte; the odd byte completes the word
          rd_pend_q <= 1'b0;
        end else if (addr == `ADDR_BURST) begin
          burst_q   <= 1'b1;
          bidx_q    <= 5'd0;
          rd_pend_q <= 1'b0;
        end else begin
          rd_addr_q <= {addr[6:1], 1'b0};
          rd_pend_q <= 1'b1;
        end
      end
      if (wr_full) begin
        case (full_addr)
          `ADDR_GYRO_X_BIAS_LOW:  bias_q[0] <= full_data;                         // [RULE20]
          `ADDR_GYRO_X_BIAS_HIGH: bias_q[1] <= full_data;
          `ADDR_GYRO_Y_BIAS_LOW:  bias_q[2] <= full_data;
          `ADDR_GYRO_Y_BIAS_HIGH: bias_q[3] <= full_data;
          `ADDR_GYRO_Z_BIAS_LOW:  bias_q[4] <= full_data;
          `ADDR_GYRO_Z_BIAS_HIGH: bias_q[5] <= full_data;
          `ADDR_MISC_CONTROL:     misc_q    <= full_data;
          `ADDR_BIAS_EST_CONFIG:  est_cfg_q <= full_data;                         // [RULE16]
          `ADDR_GLOBAL_COMMAND: begin
            if (full_data[`CMD_BIAS_UPDATE_BIT]) begin
              for (k = 0; k < 3; k = k + 1) begin
                bias_q[2*k]   <= i_bias_estimate[32*k +: 16];                     // [RULE17]
                bias_q[2*k+1] <= i_bias_estimate[32*k+16 +: 16];
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Byte write pairing
  // ----------------------------------------
  // Writes carry one byte each; even address byte is held until its odd partner

  assign wr_full   = word_done & ~burst_q & wr & addr[0] & low_valid_q
                     & (low_addr_q == {addr[6:1], 1'b0});
  assign full_addr = low_addr_q;
  assign full_data = {rx[7:0], low_byte_q};

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      low_byte_q  <= 8'h00;
      low_addr_q  <= 7'h00;
      low_valid_q <= 1'b0;
    end else if (word_done & ~burst_q & wr) begin
      low_byte_q  <= rx[7:0];
      low_addr_q  <= addr;
      low_valid_q <= ~addr[0];
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Bias applied every cycle so a write is visible at once
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_miso               <= 1'b0;
      o_gyro_corrected     <= 96'h0;
      o_axis_estimate_en   <= 6'h00;
      o_estimate_time_base <= 4'h0;
      o_flash_backup       <= 96'h0;
    end else begin
      o_miso <= shift_miso;
      for (m = 0; m < 3; m = m + 1) begin
        o_gyro_corrected[32*m +: 32] <= i_factory_gyro[32*m +: 32]
                                        + {bias_q[2*m+1], bias_q[2*m]};          // [RULE14] [RULE15] [RULE18]
        o_flash_backup[32*m +: 32]   <= {bias_q[2*m+1], bias_q[2*m]};            // [RULE19]
      end
      o_axis_estimate_en   <= est_cfg_q[`EST_AXIS_EN_HI:`EST_AXIS_EN_LO];         // [RULE16]
      o_estimate_time_base <= est_cfg_q[`EST_TIME_BASE_HI:`EST_TIME_BASE_LO];
    end
  end
endmodule // imu_burst_checksum_bias_regs

/* File: imu_burst_checksum_bias_regs_asserts.sv */
// Purpose: Port-level checks for the burst, checksum and bias block
// Assumes: Serial pins are seen raw on i_clk, ahead of the block's own sync stages
// Notes:   Bound from the bench top file
module imu_regs_checker (
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic        i_cs_b,
  input wire logic        i_sclk,
  input wire logic [95:0] i_factory_gyro,
  input wire logic        o_miso,
  input wire logic [95:0] o_gyro_corrected,
  input wire logic [5:0]  o_axis_estimate_en,
  input wire logic [3:0]  o_estimate_time_base,
  input wire logic [95:0] o_flash_backup
);
  logic       sclk_q;
  logic       cs_q;
  logic [3:0] edge_age_q;
  logic [3:0] cs_age_q;

  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  // Ages saturate so an idle link never wraps back into the window
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_q     <= 1'b1;
      cs_q       <= 1'b1;
      edge_age_q <= 4'hF;
      cs_age_q   <= 4'hF;
    end else begin
      sclk_q <= i_sclk;
      cs_q   <= i_cs_b;
      if ((sclk_q && !i_sclk) || (cs_q != i_cs_b)) begin
        edge_age_q <= 4'h0;
      end else if (edge_age_q != 4'hF) begin
        edge_age_q <= edge_age_q + 4'h1;
      end
      if (!i_cs_b) begin
        cs_age_q <= 4'h0;
      end else if (cs_age_q != 4'hF) begin
        cs_age_q <= cs_age_q + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  reset_clear_a: assert property ($rose(i_rst_b) |-> o_flash_backup == 96'h0
    && o_gyro_corrected == 96'h0 && o_axis_estimate_en == 6'h00 && o_miso == 1'b0)
    else $error("Outputs not zero after reset");
  x_corrected_a: assert property ($past(i_rst_b) |-> o_gyro_corrected[31:0] ==
    $past(i_factory_gyro[31:0]) + o_flash_backup[31:0]) else $error("X correction wrong");
  y_corrected_a: assert property ($past(i_rst_b) |-> o_gyro_corrected[63:32] ==
    $past(i_factory_gyro[63:32]) + o_flash_backup[63:32]) else $error("Y correction wrong");
  z_corrected_a: assert property ($past(i_rst_b) |-> o_gyro_corrected[95:64] ==
    $past(i_factory_gyro[95:64]) + o_flash_backup[95:64]) else $error("Z correction wrong");
  miso_edge_a: assert property ($changed(o_miso) |-> edge_age_q <= 4'h7)
    else $error("Serial output moved away from a falling edge");
  bias_quiet_a: assert property ($changed(o_flash_backup) |-> cs_age_q <= 4'hA)
    else $error("Bias changed without a host frame");
  est_en_quiet_a: assert property ($changed(o_axis_estimate_en) |-> cs_age_q <= 4'hA)
    else $error("Axis enables changed without a host frame");
  est_base_quiet_a: assert property ($changed(o_estimate_time_base) |->
    cs_age_q <= 4'hA) else $error("Time base changed without a host frame");
endmodule // imu_regs_checker

/* File: imu_host_model.sv */
// Purpose: Host serial controller driving 16-bit mode 3 frames
// Assumes: Half period of 400 ns, clock parked high between frames
// Notes:   Frames are started by the bench through the xfer task
module imu_host_model (
  input  wire logic i_miso,
  output logic      o_cs_b,
  output logic      o_sclk,
  output logic      o_mosi
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_cs_b = 1'b1;
    o_sclk = 1'b1;
    o_mosi = 1'b0;
  end

  // One whole word, MSB first, sampled on the rising edge
  task automatic xfer(input logic [15:0] tx, input int gap, output logic [15:0] rx);
    int i;
    o_cs_b = 1'b0;
    #400;
    for (i = 15; i >= 0; i--) begin
      o_sclk = 1'b0;
      o_mosi = tx[i];
      #400;
      o_sclk = 1'b1;
      rx[i] = i_miso;
      #400;
    end
    o_cs_b = 1'b1;
    o_mosi = ~o_mosi;  // Released line must not keep a stale bit
    #(gap);
  endtask
endmodule // imu_host_model

/* File: imu_burst_checksum_bias_regs_tb_top.sv */
// Purpose: Self-checking bench for bursts, transfer checksum and gyro bias
// Assumes: Fixed seed, host model on the serial pins
// Notes:   Sample data only changes between frames, so every read stays in one sample
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module imu_burst_checksum_bias_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic         i_clk, i_rst_b, i_sample_load;
  logic [191:0] i_rate, i_step;
  logic [15:0]  i_temperature, i_sample_counter, i_queued_sample_count, i_diagnostic_flags;
  logic [31:0]  i_sync_time;
  logic [95:0]  i_bias_estimate, i_factory_gyro, bias;
  wire          cs_b, sclk, mosi, o_miso;
  wire  [95:0]  o_gyro_corrected, o_flash_backup;
  wire  [5:0]   o_axis_estimate_en;
  wire  [3:0]   o_estimate_time_base;
  logic [15:0]  rx, v, mc;
  int           bad_count, n_compared, k;

  imu_burst_checksum_bias_regs dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cs_b(cs_b),
    .i_sclk(sclk), .i_mosi(mosi), .i_sample_load(i_sample_load), .i_rate(i_rate),
    .i_step(i_step), .i_temperature(i_temperature), .i_sample_counter(i_sample_counter),
    .i_sync_time(i_sync_time), .i_queued_sample_count(i_queued_sample_count),
    .i_diagnostic_flags(i_diagnostic_flags), .i_bias_estimate(i_bias_estimate),
    .i_factory_gyro(i_factory_gyro), .o_miso(o_miso), .o_gyro_corrected(o_gyro_corrected),
    .o_axis_estimate_en(o_axis_estimate_en), .o_estimate_time_base(o_estimate_time_base),
    .o_flash_backup(o_flash_backup));
  imu_host_model host_u (.i_miso(o_miso), .o_cs_b(cs_b), .o_sclk(sclk), .o_mosi(mosi));

  // ----------------------------------------
  // Expectations and bus tasks
  // ----------------------------------------
  function automatic logic [191:0] rnd192();
    return {$urandom(), $urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
  endfunction
  function automatic logic [95:0] corr(input logic [95:0] f, input logic [95:0] b);
    return {f[95:64] + b[95:64], f[63:32] + b[63:32], f[31:0] + b[31:0]};
  endfunction
  function automatic logic [15:0] bw(input int k, input logic [15:0] mc);
    logic [191:0] s;
    s = mc[8] ? i_step : i_rate;
    if (k == 0) return i_queued_sample_count;
    if (k == 1) return i_diagnostic_flags;
    if (!mc[9]) begin
      if (k <= 7) return s[32 * (k - 2) + 16 +: 16];
      if (k == 8) return i_temperature;
      return mc[1] ? i_sync_time[15:0] : i_sample_counter;
    end
    if (k <= 13) return s[16 * (k - 2) +: 16];
    if (k == 14) return i_temperature;
    if (k == 15) return mc[1] ? i_sync_time[15:0] : i_sample_counter;
    return mc[3] ? i_sync_time[31:16] : 16'h0000;
  endfunction
  // Frames start just after a clock edge so no pin moves with the sampling edge
  task automatic frame(input logic [15:0] tx, output logic [15:0] r);
    @(posedge i_clk);
    #1;
    host_u.xfer(tx, 100 * (8 + $urandom_range(0, 8)), r);
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] r;
    frame({1'b1, a, d[7:0]}, r);
    frame({1'b1, a | 7'h01, d[15:8]}, r);
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    logic [15:0] r;
    frame({1'b0, a, 8'h00}, r);
    frame(16'h0000, d);
  endtask
  // Pending answer is flushed first so the new sample period starts clean
  task automatic load();
    logic [15:0] r;
    frame(16'h0000, r);
    @(posedge i_clk);
    #1;
    i_rate = rnd192();
    i_step = rnd192();
    {i_temperature, i_sample_counter, i_sync_time} = 64'(rnd192());
    {i_queued_sample_count, i_diagnostic_flags} = $urandom();
    i_sample_load = 1'b1;
    @(posedge i_clk);
    #1;
    i_sample_load = 1'b0;
  endtask
  // Whole read inside one sample period
  task automatic burst(input logic [15:0] mc);
    logic [15:0] r, e, s;
    int j, n;
    n = mc[9] ? 17 : 10;
    s = 16'h0000;
    frame(16'h7C00, r);
    for (j = 0; j <= n; j++) begin
      frame(16'h0000, r);  // Last word fetches the checksum
      e = (j == n) ? s : bw(j, mc);
      `CHK(r, e)
      if (j >= 2 && j < n) s = s + {8'h00, e[15:8]} + {8'h00, e[7:0]};
    end
    rd(7'h3E, r);
    `CHK(r, s)
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    #9000000;
    bad_count++;
    complete_run();
  end
  initial begin
    {i_rst_b, i_sample_load, i_rate, i_step, i_temperature, i_sample_counter} = '0;
    {i_sync_time, i_queued_sample_count, i_diagnostic_flags, i_bias_estimate} = '0;
    bad_count = 0;
    n_compared = 0;
    k = $urandom(32'h9348);
    i_factory_gyro = 96'(rnd192());
    repeat (5) @(posedge i_clk);
    #1 i_rst_b = 1'b1;
    repeat (3) @(posedge i_clk);
    for (k = 0; k < 6; k++) begin
      rd(7'h40 + 7'(2 * k), rx);
      `CHK(rx, 16'h0000)
    end
    rd(7'h4C, rx);
    `CHK(rx, 16'h0000)
    for (k = 0; k < 6; k++) begin
      v = 16'($urandom());
      bias[16 * k +: 16] = v;
      wr(7'h40 + 7'(2 * k), v);
    end
    for (k = 0; k < 6; k++) begin
      rd(7'h40 + 7'(2 * k), rx);
      `CHK(rx, bias[16 * k +: 16])
    end
    `CHK(o_flash_backup, bias)
    `CHK(o_gyro_corrected, corr(i_factory_gyro, bias))
    v = 16'($urandom());
    wr(7'h66, v);
    `CHK(o_axis_estimate_en, v[13:8])
    `CHK(o_estimate_time_base, v[3:0])
    i_bias_estimate = 96'(rnd192());
    wr(7'h68, 16'h0000);
    `CHK(o_flash_backup, bias)
    wr(7'h68, 16'h0001);
    `CHK(o_flash_backup, i_bias_estimate)
    rd(7'h4A, rx);
    `CHK(rx, i_bias_estimate[95:80])
    @(posedge i_clk);
    #1 i_rst_b = 1'b0;
    repeat (5) @(posedge i_clk);
    #1 i_rst_b = 1'b1;
    repeat (3) @(posedge i_clk);
    `CHK(o_flash_backup, 96'h0)
    for (k = 0; k < 16; k++) begin
      mc = {6'h00, k[3], k[2], 4'h0, k[1], 1'b0, k[0], 1'b0};
      wr(7'h64, mc);
      load();
      burst(mc);
    end
    load();
    rd(7'h3E, rx);
    `CHK(rx, 16'h0000)
    wr(7'h40, 16'hFFFF);
    load();
    for (k = 0; k < 132; k++) frame(16'h4000, rx);
    rd(7'h3E, rx);
    `CHK(rx, 16'(132 * 510))
    complete_run();
  end
endmodule // imu_burst_checksum_bias_regs_tb_top

bind imu_burst_checksum_bias_regs imu_regs_checker chk_u (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_cs_b(i_cs_b), .i_sclk(i_sclk), .i_factory_gyro(i_factory_gyro), .o_miso(o_miso),
  .o_gyro_corrected(o_gyro_corrected), .o_axis_estimate_en(o_axis_estimate_en),
  .o_estimate_time_base(o_estimate_time_base), .o_flash_backup(o_flash_backup));
